// ===== logic/lbl_pkg.sv
// Package: constants for the long branch-if-lower execution unit
package lbl_pkg;

    // ------------------------------------------------------------
    // Encoding
    // ------------------------------------------------------------
    localparam logic [7:0]  PREFIX_PAGE      = 8'h18;
    localparam logic [7:0]  OPCODE_LOWER     = 8'h25;
    localparam logic [15:0] PC_STEP          = 16'h0004;

    // ------------------------------------------------------------
    // Timing: queue refill cycles
    // ------------------------------------------------------------
    localparam int          TAKEN_CYCLES     = 4;
    localparam int          NOTTAKEN_CYCLES  = 3;
    localparam logic [2:0]  TAKEN_CNT        = 3'(TAKEN_CYCLES);
    localparam logic [2:0]  NOTTAKEN_CNT     = 3'(NOTTAKEN_CYCLES);

    // ------------------------------------------------------------
    // Condition code register carry bit position, CCR and PC reset values
    // ------------------------------------------------------------
    localparam int          CCR_C_BIT        = 0;
    localparam logic [7:0]  CCR_RESET        = 8'hD0;
    localparam logic [15:0] PC_RESET         = 16'h0000;

    // ------------------------------------------------------------
    // Fetch sequencer states
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        ST_PREFIX = 5'b00001,
        ST_OPCODE = 5'b00010,
        ST_OFFHI  = 5'b00100,
        ST_OFFLO  = 5'b01000,
        ST_REFILL = 5'b10000
    } fetch_state_t;

endpackage

// ===== logic/branch_target_calc.sv
// Leaf: branch target and carry test
`timescale 1ns/100ps
`default_nettype none
module branch_target_calc
    import lbl_pkg::*;
(
    // Operands
    input  wire logic [15:0] pcIn,
    input  wire logic [15:0] offset,
    input  wire logic [7:0]  ccrIn,
    // Results
    output logic      [15:0] target,
    output logic             takeBranch
);
    // ------------------------------------------------------------
    // Target and condition
    // ------------------------------------------------------------
    // Offset is already 16 bits; the add wraps modulo 64K like the core
    assign target     = 16'(pcIn + PC_STEP + offset);
    // Carry set means unsigned lower after compare or subtract
    assign takeBranch = ccrIn[CCR_C_BIT];
endmodule // branch_target_calc
`default_nettype wire

// ===== logic/long_branch_if_lower_unit.sv
// Top: decode and execute of the long branch-if-lower instruction
`timescale 1ns/100ps
`default_nettype none
// Summary of operation
// - Carry set loads PC plus four plus offset
// - Taken means accumulator below memory, unsigned
// - Register below memory after compare or subtract
// - Second accumulator below first after accumulator ops
// - Four refill cycles taken, three not taken
// - Prefix page then opcode then two offset bytes
module long_branch_if_lower_unit
    import lbl_pkg::*;
(
    // Clock and reset
    input  wire logic        core_clk,
    input  wire logic        srst,
    // Instruction queue
    input  wire logic        queueValid,
    input  wire logic [7:0]  queueByte,
    output logic             queueTake,
    // Core state in
    input  wire logic [15:0] pcCurrent,
    input  wire logic [7:0]  ccrCurrent,
    // Core state out
    output logic [15:0]      pcOut,
    output logic             pcLoad,
    output logic [7:0]       ccrOut,
    output logic             busy,
    output logic             done,
    output logic             branchTaken
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    fetch_state_t state_r, state_nxt;
    logic [15:0]  pcHold_r, pcHold_nxt;
    logic [7:0]   offHi_r, offHi_nxt;
    logic [7:0]   ccr_r, ccr_nxt;
    logic [2:0]   cnt_r, cnt_nxt;
    logic         taken_r, taken_nxt;
    logic [15:0]  pcOut_r, pcOut_nxt;
    logic         pcLoad_r, pcLoad_nxt;
    logic         done_r, done_nxt;
    logic         take_r, take_nxt;
    logic         busy_r, busy_nxt;
    logic [15:0]  target;
    logic         takeBranch;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Fall-through address when the carry is clear
    function automatic logic [15:0] seqPc(input logic [15:0] pc);
        return 16'(pc + PC_STEP);
    endfunction

    // Cycles left after the last offset byte; the final one
    // is the cycle in which pcLoad rises
    function automatic logic [2:0] refillCount(input logic taken);
        return taken ? 3'(TAKEN_CNT - 3'h1) : 3'(NOTTAKEN_CNT - 3'h1);
    endfunction

    // Shared by the sequencer and the result strobes
    function automatic logic lastRefill(input logic [2:0] cnt);
        return cnt == 3'h1;
    endfunction

    branch_target_calc u_calc (
        .pcIn       (pcHold_r),
        .offset     ({offHi_r, queueByte}),
        .ccrIn      (ccr_r),
        .target     (target),
        .takeBranch (takeBranch)
    );

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        state_nxt  = state_r;
        pcHold_nxt = pcHold_r;
        offHi_nxt  = offHi_r;
        ccr_nxt    = ccr_r;
        cnt_nxt    = cnt_r;
        take_nxt   = 1'b0;
        unique case (state_r)
            ST_PREFIX:
            begin
                if (queueValid)
                begin
                    // Other opcodes are taken from the queue too but leave the state in ST_PREFIX
                    if (queueByte == PREFIX_PAGE)
                    begin
                        state_nxt  = ST_OPCODE;
                        pcHold_nxt = pcCurrent;
                        ccr_nxt    = ccrCurrent;
                    end
                    take_nxt = 1'b1;
                end
            end
            ST_OPCODE:
            begin
                if (queueValid)
                begin
                    take_nxt  = 1'b1;
                    // Same code for the carry-set alias
                    state_nxt = (queueByte == OPCODE_LOWER) ? ST_OFFHI : ST_PREFIX;
                end
            end
            ST_OFFHI:
            begin
                if (queueValid)
                begin
                    take_nxt  = 1'b1;
                    offHi_nxt = queueByte;
                    state_nxt = ST_OFFLO;
                end
            end
            ST_OFFLO:
            begin
                if (queueValid)
                begin
                    take_nxt  = 1'b1;
                    cnt_nxt   = refillCount(takeBranch);
                    state_nxt = ST_REFILL;
                end
            end
            ST_REFILL:
            begin
                // Queue is refilled during these cycles, nothing fetched
                if (lastRefill(cnt_r))
                begin
                    state_nxt  = ST_PREFIX;
                end
                cnt_nxt = 3'(cnt_r - 3'h1);
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            state_r  <= ST_PREFIX;
            pcHold_r <= PC_RESET;
            offHi_r  <= 8'h00;
            ccr_r    <= CCR_RESET;
            cnt_r    <= 3'h0;
            take_r   <= 1'b0;
        end
        else
        begin
            state_r  <= state_nxt;
            pcHold_r <= pcHold_nxt;
            offHi_r  <= offHi_nxt;
            ccr_r    <= ccr_nxt;
            cnt_r    <= cnt_nxt;
            take_r   <= take_nxt;
        end
    end

    // ------------------------------------------------------------
    // Results
    // ------------------------------------------------------------
    // Latched as the last offset byte lands, so pcOut is steady
    // through the refill and the core may sample it early
    always_comb
    begin
        taken_nxt  = taken_r;
        pcOut_nxt  = pcOut_r;
        pcLoad_nxt = 1'b0;
        done_nxt   = 1'b0;
        // Registered from the next state so busy rises with the edge
        // that takes the prefix and falls with the one ending refill
        busy_nxt   = (state_nxt != ST_PREFIX);
        if (state_r == ST_OFFLO && queueValid)
        begin
            taken_nxt = takeBranch;
            pcOut_nxt = takeBranch ? target : seqPc(pcHold_r);
        end
        if (state_r == ST_REFILL && lastRefill(cnt_r))
        begin
            pcLoad_nxt = 1'b1;
            done_nxt   = 1'b1;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            taken_r  <= 1'b0;
            pcOut_r  <= PC_RESET;
            pcLoad_r <= 1'b0;
            done_r   <= 1'b0;
            busy_r   <= 1'b0;
        end
        else
        begin
            taken_r  <= taken_nxt;
            pcOut_r  <= pcOut_nxt;
            pcLoad_r <= pcLoad_nxt;
            done_r   <= done_nxt;
            busy_r   <= busy_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Flags are passed back as captured: the branch writes none of them
    assign ccrOut      = ccr_r;
    assign pcOut       = pcOut_r;
    assign pcLoad      = pcLoad_r;
    assign done        = done_r;
    assign branchTaken = taken_r;
    assign queueTake   = take_r;
    assign busy        = busy_r;
endmodule // long_branch_if_lower_unit
`default_nettype wire

// ===== dv/long_branch_if_lower_properties.sv
// Checker: timing, target and flag properties of the long branch unit
`timescale 1ns/100ps
`default_nettype none
module long_branch_if_lower_checker
(
    // Watched ports
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        queueValid,
    input wire logic [7:0]  queueByte,
    input wire logic        queueTake,
    input wire logic [15:0] pcCurrent,
    input wire logic [7:0]  ccrCurrent,
    input wire logic [15:0] pcOut,
    input wire logic        pcLoad,
    input wire logic [7:0]  ccrOut,
    input wire logic        busy,
    input wire logic        done,
    input wire logic        branchTaken
);
    // ----------
    // Properties
    // ----------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (srst);
    // Prefix, opcode and both offset bytes with no gaps
    sequence sFetch(bit c);
        queueValid && queueByte == 8'h18 && !busy && ccrCurrent[0] == c
        ##1 queueValid && queueByte == 8'h25 ##1 queueValid [*2];
    endsequence
    chk_taken_time: assert property (sFetch(1) |-> !pcLoad [*4] ##1 pcLoad && branchTaken)
        else $error("taken branch completes at wrong cycle");
    chk_skip_time: assert property (sFetch(0) |-> !pcLoad [*3] ##1 pcLoad && !branchTaken)
        else $error("untaken branch completes at wrong cycle");
    chk_taken_target: assert property (sFetch(1) |-> ##4 pcOut == $past(pcCurrent, 7)
        + 16'h0004 + {$past(queueByte, 5), $past(queueByte, 4)})
        else $error("taken target wrong");
    chk_skip_pc: assert property (sFetch(0) |-> ##3 pcOut == $past(pcCurrent, 6) + 16'h0004)
        else $error("sequential pc wrong");
    chk_flags_kept: assert property (sFetch(1) |-> ##4 ccrOut == $past(ccrCurrent, 7))
        else $error("condition codes changed");
    chk_done_load: assert property (done == pcLoad)
        else $error("done and pc load differ");
    chk_fetch_ack: assert property (queueValid && !busy |=> queueTake)
        else $error("idle byte not acknowledged");
    chk_bad_opcode: assert property (queueValid && queueByte == 8'h18 && !busy
        ##1 queueValid && queueByte != 8'h25 |=> !busy && !pcLoad)
        else $error("foreign opcode not dropped");
endmodule // long_branch_if_lower_checker
`default_nettype wire

// ===== dv/long_branch_if_lower_unit_test.sv
// Testbench: directed scenarios for the long branch-if-lower unit
`timescale 1ns/100ps
`default_nettype none
module long_branch_if_lower_unit_test
    import lbl_pkg::*;
;
    logic        core_clk = 0, srst = 1, queueValid = 0;
    logic        queueTake, pcLoad, busy, done, branchTaken;
    logic [7:0]  queueByte = 8'h00, ccrCurrent = 8'h00, ccrOut;
    logic [15:0] pcCurrent = 16'h0000, pcOut;
    int          n_fail = 0, check_count = 0, cycles = 0;

    long_branch_if_lower_unit u_dut (.core_clk(core_clk), .srst(srst), .queueValid(queueValid),
        .queueByte(queueByte), .queueTake(queueTake), .pcCurrent(pcCurrent),
        .ccrCurrent(ccrCurrent), .pcOut(pcOut), .pcLoad(pcLoad), .ccrOut(ccrOut),
        .busy(busy), .done(done), .branchTaken(branchTaken));

    // ---------------
    // Clock and guard
    // ---------------
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk)
    begin
        cycles <= cycles + 1;
        if (cycles == 3000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp)
        begin
            n_fail++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic put(input logic [7:0] b);
        @(negedge core_clk);
        queueValid = 1'b1;
        queueByte = b;
    endtask
    // Carry as left by a compare of r against m
    function automatic logic [7:0] flags(input logic [15:0] r, input logic [15:0] m);
        return {7'h68, r < m};
    endfunction
    task automatic branch(input logic [15:0] pc, input logic [7:0] condition_code_register, input logic [15:0] off);
        int n;
        n = 1;
        put(PREFIX_PAGE);
        pcCurrent = pc;
        ccrCurrent = condition_code_register;
        put(OPCODE_LOWER);
        check({15'h0000, busy}, 16'h0001);
        check({15'h0000, queueTake}, 16'h0001);
        put(off[15:8]);
        put(off[7:0]);
        @(negedge core_clk);
        queueValid = 1'b0;
        while (done !== 1'b1 && n < 9)
        begin
            @(negedge core_clk);
            n++;
        end
        check(16'(n), 16'(condition_code_register[0] ? TAKEN_CYCLES : NOTTAKEN_CYCLES));
        check({15'h0000, pcLoad}, 16'h0001);
        check(pcOut, pc + PC_STEP + (condition_code_register[0] ? off : 16'h0000));
        check({15'h0000, branchTaken}, {15'h0000, condition_code_register[0]});
        check({8'h00, ccrOut}, {8'h00, condition_code_register});
    endtask

    // ---------
    // Scenarios
    // ---------
    task automatic t_reg_compare();
        branch(16'h4000, flags(16'h0100, 16'h0200), 16'hFFF0);
        branch(16'h4010, flags(16'h0200, 16'h0100), 16'h0020);
        branch(16'h4020, flags(16'h0300, 16'h0300), 16'h0020);
        $display("register compare done");
    endtask
    task automatic t_acc_compare();
        branch(16'h8000, flags(16'h0012, 16'h0034), 16'h0100);
        branch(16'h8004, flags(16'h0034, 16'h0012), 16'h0100);
        $display("accumulator compare done");
    endtask
    task automatic t_flags_kept();
        branch(16'hFFF0, 8'hFF, 16'h7FFF);
        branch(16'h1234, 8'hFE, 16'h8000);
        $display("flags kept done");
    endtask
    task automatic t_bad_opcode();
        put(PREFIX_PAGE);
        put(8'h24);
        put(8'h12);
        @(negedge core_clk);
        queueValid = 1'b0;
        repeat (6) @(negedge core_clk) check({15'h0000, done}, 16'h0000);
        branch(16'h2000, 8'h01, 16'h0002);
        $display("foreign opcode done");
    endtask

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    initial
    begin
        repeat (16) @(negedge core_clk);
        srst = 1'b0;
        t_reg_compare();
        t_acc_compare();
        t_flags_kept();
        t_bad_opcode();
        end_of_test();
    end
endmodule // long_branch_if_lower_unit_test

bind long_branch_if_lower_unit long_branch_if_lower_checker u_chk (.core_clk(core_clk),
    .srst(srst), .queueValid(queueValid), .queueByte(queueByte), .queueTake(queueTake),
    .pcCurrent(pcCurrent), .ccrCurrent(ccrCurrent), .pcOut(pcOut), .pcLoad(pcLoad),
    .ccrOut(ccrOut), .busy(busy), .done(done), .branchTaken(branchTaken));
`default_nettype wire
